// ===== shared/analog_io_defs.svh
`ifndef ANALOG_IO_DEFS_SVH
`define ANALOG_IO_DEFS_SVH

// Data width of bus and holding registers
`define DATA_W            8
// Reset value of every holding register
`define HOLD_RST          8'h00
// Conversion clock cycles per conversion
`define CONV_CYCLES       8
// Core clock period and conversion clock half period in ns
`define CORE_PERIOD_NS    50
`define CONV_HALF_NS      125
// Core cycles per conversion clock half period, rounded down, at least one
`define CONV_HALF_CYC ((`CONV_HALF_NS / `CORE_PERIOD_NS) < 1 ? 1 : \
                       (`CONV_HALF_NS / `CORE_PERIOD_NS))

`endif

// ===== shared/analog_io_pkg.sv
package analog_io_pkg;
    // Byte carried on the bus and in each register
    typedef logic [7:0] byte_t;
    // Converter sequencing
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_DONE
    } conv_state_e;
endpackage

// ===== design/sar_core.sv
`timescale 1ns/1ns
`include "analog_io_defs.svh"

// Successive approximation sequencer; result held in a register
module sar_core
    import analog_io_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // Control
    input  wire logic                 start,
    input  wire logic                 conv_tick,
    input  wire analog_io_pkg::byte_t sample,
    // Status and result
    output logic                      running,
    output logic                      done,
    output analog_io_pkg::byte_t      result
);
    logic [3:0] step_q, step_d;
    byte_t      sar_q, sar_d;
    byte_t      res_q, res_d;
    logic       run_q, run_d;
    logic       done_q, done_d;

    // One bit decided per conversion clock, MSB first; a running
    // conversion carries on through reset, an idle core's sequencer is cleared
    always_comb begin
        step_d = step_q;
        sar_d  = sar_q;
        res_d  = res_q;
        run_d  = run_q;
        done_d = 1'b0;
        if (run_q) begin
            if (conv_tick) begin
                sar_d[3'(7 - step_q)] = sample[3'(7 - step_q)];
                if (step_q == 4'(`CONV_CYCLES - 1)) begin  // [RULE20]
                    // Result to output latch, SAR cleared
                    res_d  = sar_d;
                    sar_d  = 8'h00;
                    run_d  = 1'b0;
                    done_d = 1'b1;
                end else begin
                    step_d = step_q + 4'h1;
                end
            end
        end else if (!rst_n) begin
            // Idle under reset: sequencer cleared, result latch kept
            step_d = 4'h0;
            sar_d  = 8'h00;
            run_d  = 1'b0;
        end else if (start) begin
            run_d  = 1'b1;
            step_d = 4'h0;
            sar_d  = 8'h00;
        end
    end

    // State registers; reset acts through the next-state logic above
    always_ff @(posedge core_clk) begin
        step_q <= step_d;
        sar_q  <= sar_d;
        res_q  <= res_d;
        run_q  <= run_d;
        done_q <= done_d;
    end

    assign running = run_q;
    assign done    = done_q;
    assign result  = res_q;
endmodule // sar_core

// ===== design/analog_io_bus_interface.sv
`timescale 1ns/1ns
`include "analog_io_defs.svh"

// Notes on behaviour
// [RULE1] Rising write edge loads data bus
// [RULE2] Edge-triggered; held low changes nothing
// [RULE3] Whichever of select/write rises first loads
// [RULE4] Reset low zeros every holding register
// [RULE5] Two holding registers share the bus
// [RULE6] Channel low picks A, high picks B
// [RULE7] Host keeps channel stable during write
// [RULE8] Start falling edge starts conversion, holds
// [RULE9] Busy low during conversion; track after
// [RULE10] Interrupt low at end of conversion
// [RULE11] Read returns result; ends clear interrupt
// [RULE12] Host keeps start low while reading
// [RULE13] Host never reads during conversion
// [RULE14] Host never restarts during conversion
// [RULE15] Host widens start pulse for mux
// [RULE16] Start tied high selects read-start mode
// [RULE17] Read falling edge samples, busy stalls
// [RULE18] Old data during conversion, new after
// [RULE19] Host tolerates wait state per read
// [RULE20] Eight conversion clocks, then latch result
// [RULE21] Reset spares conversion, clears interrupt
// [RULE22] Coding follows supply: binary or two's
module analog_io_bus_interface
    import analog_io_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // Bus control, active low except chan_b
    input  wire logic                 cs_n,
    input  wire logic                 wr_n,
    input  wire logic                 rd_n,
    input  wire logic                 chan_b,
    input  wire logic                 start_convert_n,
    // Data bus, split
    input  wire analog_io_pkg::byte_t data_in,
    output analog_io_pkg::byte_t      data_out,
    output logic                      data_oe,
    // Converter side
    input  wire analog_io_pkg::byte_t sample_in,
    input  wire logic                 neg_supply,
    output logic                      hold,
    output logic                      busy_n,
    output logic                      int_n,
    output analog_io_pkg::byte_t      holding_reg_a,
    output analog_io_pkg::byte_t      holding_reg_b
);
    logic   cs_q, wr_q, rd_q, st_q;
    byte_t  reg_a_q, reg_a_d, reg_b_q, reg_b_d;
    logic   int_q, int_d;
    logic   [3:0] div_q, div_d;
    logic   tick_q, tick_d;
    logic   wr_act, wr_act_q, wr_end, rd_act, rd_act_q, rd_end, rd_fall;
    logic   st_fall, start, running, done;
    byte_t  result, shown;

    // Checks below share this clock and are off while reset is low
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Edge detection on the bus strobes
    assign wr_act   = !cs_n && !wr_n;
    assign wr_act_q = !cs_q && !wr_q;
    assign wr_end   = wr_act_q && !wr_act;                // [RULE3]
    assign rd_act   = !cs_n && !rd_n;
    assign rd_act_q = !cs_q && !rd_q;
    assign rd_end   = rd_act_q && !rd_act;
    assign rd_fall  = rd_act && rd_q && !cs_n;            // [RULE17]
    assign st_fall  = st_q && !start_convert_n;           // [RULE8]

    // Start source: start pin, or read when pin tied high
    assign start = st_fall ||
                   (start_convert_n && st_q && rd_fall);  // [RULE16]

    // Holding registers load on end of write overlap
    always_comb begin
        reg_a_d = reg_a_q;
        reg_b_d = reg_b_q;
        if (wr_end) begin                                 // [RULE1] [RULE2]
            if (chan_b) begin                             // [RULE6]
                reg_b_d = data_in;                        // [RULE5]
            end else begin
                reg_a_d = data_in;
            end
        end
    end

    // Interrupt: set at done, cleared at read end; set wins
    always_comb begin
        int_d = int_q;
        if (rd_end) begin
            int_d = 1'b0;                                 // [RULE11]
        end
        if (done) begin
            int_d = 1'b1;                                 // [RULE10]
        end
    end

    // Conversion clock divider
    always_comb begin
        div_d  = div_q + 4'h1;
        tick_d = 1'b0;
        if (!running) begin
            div_d = 4'h0;
        end else if (div_q == 4'(2 * `CONV_HALF_CYC - 1)) begin
            div_d  = 4'h0;
            tick_d = 1'b1;
        end
    end

    // Holding registers and interrupt: reset forces them
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_a_q <= `HOLD_RST;                         // [RULE4]
            reg_b_q <= `HOLD_RST;
            int_q   <= 1'b0;                              // [RULE21]
        end else begin
            reg_a_q <= reg_a_d;
            reg_b_q <= reg_b_d;
            int_q   <= int_d;
        end
    end

    // Strobe history and divider; not reset-sensitive to spare conversion
    always_ff @(posedge core_clk) begin
        cs_q   <= cs_n;
        wr_q   <= wr_n;
        rd_q   <= rd_n;
        st_q   <= start_convert_n;
        div_q  <= div_d;
        tick_q <= tick_d;
    end

    // Converter core
    sar_core u_sar (
        .core_clk  (core_clk),
        .rst_n     (rst_n),                              // [RULE21]
        .start     (start),
        .conv_tick (tick_q),
        .sample    (sample_in),
        .running   (running),
        .done      (done),
        .result    (result)
    );

    // Coding per supply: flip MSB for two's complement
    assign shown = neg_supply ? {~result[7], result[6:0]}
                              : result;                   // [RULE22]

    // Outputs
    assign data_out      = shown;                         // [RULE18]
    assign data_oe       = rd_act;
    assign busy_n        = !running;                      // [RULE9]
    assign hold          = running;
    assign int_n         = !int_q;
    assign holding_reg_a = reg_a_q;
    assign holding_reg_b = reg_b_q;

    // Checks: write path, selected register takes the bus
    wr_a_load_a: assert property ( // [RULE6]
        wr_end && !chan_b |=> holding_reg_a == $past(data_in))
        else $error("reg a not loaded");

    wr_b_load_a: assert property ( // [RULE5]
        wr_end && chan_b |=> holding_reg_b == $past(data_in))
        else $error("reg b not loaded");

    wr_hold_a: assert property ( // [RULE2]
        !wr_end |=> $stable(holding_reg_a) && $stable(holding_reg_b))
        else $error("register changed without write end");

    // Reset release: registers zero, interrupt inactive
    rst_zero_a: assert property ( // [RULE4]
        $rose(rst_n) |-> holding_reg_a == `HOLD_RST &&
                         holding_reg_b == `HOLD_RST)
        else $error("holding register not cleared by reset");

    int_rst_a: assert property ( // [RULE21]
        $rose(rst_n) |-> int_n)
        else $error("interrupt not cleared by reset");

    // Conversion: busy low for 33 cycles after start, fixed length
    sequence conv_start_s;
        busy_n && start;
    endsequence

    sequence conv_end_s;
        !busy_n ##1 busy_n;
    endsequence

    busy_low_a: assert property ( // [RULE9]
        conv_start_s |=> !busy_n [*8])
        else $error("busy not held low");

    busy_end_a: assert property ( // [RULE20]
        conv_start_s |-> ##33 conv_end_s)
        else $error("conversion length wrong");

    // Interrupt: raised after busy rises, held until a read ends
    int_set_a: assert property ( // [RULE10]
        $rose(busy_n) |=> !int_n)
        else $error("interrupt not raised");

    int_keep_a: assert property ( // [RULE10]
        !int_n && !rd_end |=> !int_n)
        else $error("interrupt dropped before read end");

    int_clr_a: assert property ( // [RULE11]
        rd_end && !done |=> int_n)
        else $error("interrupt not cleared");

    // Start sources: falling start line, or read with the line tied high
    st_start_a: assert property ( // [RULE8]
        st_fall && busy_n |=> !busy_n && hold)
        else $error("start edge ignored");

    rd_start_a: assert property ( // [RULE17]
        rd_fall && start_convert_n && st_q && busy_n |=> !busy_n)
        else $error("read did not start");
endmodule // analog_io_bus_interface

// ===== dv/host_model.sv
`timescale 1ns/1ns

// Host bus master: strobes, channel select, start line
module host_model (
    // Clock
    input  wire logic                 core_clk,
    // Bus drive
    output logic                      cs_n,
    output logic                      wr_n,
    output logic                      rd_n,
    output logic                      chan_b,
    output logic                      start_convert_n,
    output analog_io_pkg::byte_t      data_in,
    // Device answers
    input  wire logic                 busy_n,
    input  wire analog_io_pkg::byte_t data_out
);
    import analog_io_pkg::*;

    // Idle levels
    initial begin
        {cs_n, wr_n, rd_n, start_convert_n} = 4'hf;
        chan_b = 1'b0;
        data_in = 8'h00;
    end

    // Open a write; channel held until the end
    task automatic write_low(input logic chan, input byte_t d);
        @(negedge core_clk);
        chan_b = chan;
        data_in = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
    endtask

    // Close a write by either strobe, then one idle cycle
    task automatic write_end(input logic cs_first);
        @(negedge core_clk);
        if (cs_first) cs_n = 1'b1;
        else wr_n = 1'b1;
        @(negedge core_clk);
        {cs_n, wr_n} = 2'h3;
        data_in = ~data_in;
        @(negedge core_clk);
    endtask

    // Start line; kept low through conversion and read
    task automatic set_start(input logic v);
        @(negedge core_clk);
        start_convert_n = v;
    endtask

    // Read; waits out busy as a wait state
    task automatic read(output byte_t early, output byte_t late);
        int n;
        @(negedge core_clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (2) @(negedge core_clk);
        early = data_out;
        for (n = 0; n < 80 && busy_n !== 1'b1; n++)
            @(negedge core_clk);
        @(negedge core_clk);
        late = data_out;
        {cs_n, rd_n} = 2'h3;
    endtask
endmodule // host_model

// ===== dv/tb_top.sv
`timescale 1ns/1ns

// Self-checking bench for the bus interface
module tb_top;
    import analog_io_pkg::*;

    // Clock, reset, converter stand-ins and bus wires
    logic  core_clk, rst_n, neg_supply, cs_n, wr_n, rd_n, chan_b;
    logic  start_convert_n, data_oe, hold, busy_n, int_n;
    byte_t sample_in, data_in, data_out, holding_reg_a, holding_reg_b;
    byte_t early, late;
    int    n_mismatch, n_checks;

    host_model host_model_i (.core_clk(core_clk), .cs_n(cs_n),
        .wr_n(wr_n), .rd_n(rd_n), .chan_b(chan_b),
        .start_convert_n(start_convert_n), .data_in(data_in),
        .busy_n(busy_n), .data_out(data_out));

    analog_io_bus_interface analog_io_bus_interface_i (
        .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .chan_b(chan_b), .start_convert_n(start_convert_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .sample_in(sample_in), .neg_supply(neg_supply), .hold(hold),
        .busy_n(busy_n), .int_n(int_n), .holding_reg_a(holding_reg_a),
        .holding_reg_b(holding_reg_b));

    // Clock
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;

    // Compare and count
    task automatic chk(input byte_t got, input byte_t exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Wait for busy level, bounded; returns cycles taken
    task automatic wait_busy(input logic lvl, output int n);
        for (n = 0; n < 80 && busy_n !== lvl; n++) @(negedge core_clk);
    endtask

    // Writes to both registers, both terminating strobes
    task automatic t_writes();
        host_model_i.write_low(1'b0, 8'ha5);
        repeat (3) @(negedge core_clk);
        chk(holding_reg_a, 8'h00);
        host_model_i.write_end(1'b0);
        chk(holding_reg_a, 8'ha5);
        chk(holding_reg_b, 8'h00);
        host_model_i.write_low(1'b1, 8'h3c);
        host_model_i.write_end(1'b1);
        chk(holding_reg_b, 8'h3c);
        chk(holding_reg_a, 8'ha5);
    endtask

    // Start-pulse conversion, read, interrupt clear
    task automatic t_mode1();
        int n;
        sample_in = 8'h5a;
        host_model_i.set_start(1'b0);
        wait_busy(1'b0, n);
        chk({7'h00, hold}, 8'h01);
        wait_busy(1'b1, n);
        chk({7'h00, n >= 28 && n <= 38}, 8'h01);
        chk({7'h00, hold}, 8'h00);
        @(negedge core_clk);
        chk({7'h00, int_n}, 8'h00);
        host_model_i.read(early, late);
        chk(late, 8'h5a);
        repeat (2) @(negedge core_clk);
        chk({7'h00, int_n}, 8'h01);
        host_model_i.set_start(1'b1);
    endtask

    // Reset during and after a conversion
    task automatic t_reset_mid();
        int n;
        sample_in = 8'h81;
        host_model_i.set_start(1'b0);
        wait_busy(1'b0, n);
        rst_n = 1'b0;
        @(negedge core_clk);
        chk(holding_reg_a | holding_reg_b, 8'h00);
        rst_n = 1'b1;
        chk({7'h00, busy_n}, 8'h00);
        wait_busy(1'b1, n);
        @(negedge core_clk);
        rst_n = 1'b0;
        @(negedge core_clk);
        chk({7'h00, int_n}, 8'h01);
        rst_n = 1'b1;
        host_model_i.read(early, late);
        chk(late, 8'h81);
        host_model_i.set_start(1'b1);
    endtask

    // Read-started conversion, old then new data, signed coding
    task automatic t_mode2();
        neg_supply = 1'b1;
        sample_in = 8'hc3;
        fork
            host_model_i.read(early, late);
            begin
                repeat (3) @(negedge core_clk);
                chk({7'h00, data_oe}, 8'h01);
                chk({7'h00, busy_n}, 8'h00);
            end
        join
        chk(early, 8'h01);
        chk(late, 8'h43);
    endtask

    // Verdict and end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        {n_mismatch, n_checks} = '0;
        {rst_n, neg_supply} = 2'h0;
        sample_in = 8'h00;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        chk(holding_reg_a | holding_reg_b, 8'h00);
        chk({6'h00, int_n, busy_n}, 8'h03);
        t_writes();
        t_mode1();
        t_reset_mid();
        t_mode2();
        give_verdict();
    end

    // Watchdog
    initial begin
        #(50 * 3000);
        n_mismatch++;
        give_verdict();
    end
endmodule // tb_top
